//--- verilog/can_acceptance_filter.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module can_acceptance_filter (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // axi4-lite write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // axi4-lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // axi4-lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // axi4-lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // frame from the receive core
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_frame_ok,
  input  wire logic [10:0] i_rx_std_id,
  input  wire logic        i_rx_ide,
  input  wire logic        i_rx_rtr,
  input  wire logic [17:0] i_rx_ext_id,
  // store request to the receive fifo
  output logic             o_fifo_wr,
  output logic [7:0]       o_fifo_match_index
);

  // ****************************************************************
  // decode functions
  // ****************************************************************

  // layout of filter f for a scale: {exists, kind, id byte, second byte, high half}
  function automatic logic [9:0] filter_layout(input logic [1:0] scale, input int f);
    logic [9:0] r;
    r = 10'h000;
    case (scale)
      acc_filter_pkg::SCALE_32: begin
        if (f == 0) r = {1'b1, acc_filter_pkg::KIND_32, 3'h0, 3'h4, 1'b0};
      end
      acc_filter_pkg::SCALE_16X2: begin
        if (f == 0) r = {1'b1, acc_filter_pkg::KIND_16, 3'h0, 3'h2, 1'b0};
        if (f == 1) r = {1'b1, acc_filter_pkg::KIND_16, 3'h4, 3'h6, 1'b1};
      end
      acc_filter_pkg::SCALE_16_8X2: begin
        if (f == 0) r = {1'b1, acc_filter_pkg::KIND_16, 3'h0, 3'h2, 1'b0};
        if (f == 1) r = {1'b1, acc_filter_pkg::KIND_8, 3'h4, 3'h5, 1'b1};
        if (f == 2) r = {1'b1, acc_filter_pkg::KIND_8, 3'h6, 3'h7, 1'b1};
      end
      default: begin // four 8-bit filters
        if (f == 0) r = {1'b1, acc_filter_pkg::KIND_8, 3'h0, 3'h1, 1'b0};
        if (f == 1) r = {1'b1, acc_filter_pkg::KIND_8, 3'h2, 3'h3, 1'b0};
        if (f == 2) r = {1'b1, acc_filter_pkg::KIND_8, 3'h4, 3'h5, 1'b1};
        if (f == 3) r = {1'b1, acc_filter_pkg::KIND_8, 3'h6, 3'h7, 1'b1};
      end
    endcase
    return r;
  endfunction : filter_layout

  // left-aligned field of a bank starting at byte p
  function automatic logic [31:0] bank_field(input logic [63:0] bb, input logic [2:0] p,
                                             input logic [1:0] kind);
    logic [31:0] v;
    v = {bb[8*p +: 8], 24'h000000};
    if (kind != acc_filter_pkg::KIND_8) v[23:16] = bb[8*(p+3'h1) +: 8];
    if (kind == acc_filter_pkg::KIND_32) begin
      v[15:8] = bb[8*(p+3'h2) +: 8];
      v[7:0]  = bb[8*(p+3'h3) +: 8];
    end
    return v;
  endfunction : bank_field

  // compared bits per width
  function automatic logic [31:0] width_mask(input logic [1:0] kind);
    case (kind)
      acc_filter_pkg::KIND_32: return acc_filter_pkg::WMASK_32;
      acc_filter_pkg::KIND_16: return acc_filter_pkg::WMASK_16;
      default:                 return acc_filter_pkg::WMASK_8;
    endcase
  endfunction : width_mask

  // decode of a word-aligned byte address
  function automatic logic addr_is_bank(input logic [7:0] a);
    return (a <= acc_filter_pkg::ADDR_BANK_LAST);
  endfunction : addr_is_bank

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [31:0] bank_word [acc_filter_pkg::NUM_WORDS]; // two words per bank
  logic [31:0] next_bank_word [acc_filter_pkg::NUM_WORDS];
  logic [31:0] cfg_reg;          // active bits and scales
  logic [31:0] next_cfg_reg;
  logic [31:0] mode_reg;         // low and high list-mode bits
  logic [31:0] next_mode_reg;
  logic        aw_full;          // write address held
  logic        next_aw_full;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic        w_full;           // write data held
  logic        next_w_full;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [5:0]  bank_active;
  logic [5:0]  low_half_list_mode;
  logic [5:0]  high_half_list_mode;

  assign bank_active         = cfg_reg[acc_filter_pkg::CFG_ACTIVE_POS +: 6];
  assign low_half_list_mode  = mode_reg[acc_filter_pkg::MODE_LOW_POS +: 6];
  assign high_half_list_mode = mode_reg[acc_filter_pkg::MODE_HIGH_POS +: 6];

  // ****************************************************************
  // filter evaluation state
  // ****************************************************************
  logic        rx_q;             // frame registered for evaluation
  logic        rx_ok_q;
  logic [31:0] key_q;            // {std, rtr, ide, ext, pad}
  logic        found;            // any active filter hit
  logic [7:0]  best_idx;
  logic [1:0]  best_rank;        // 0 best: list full, 3 worst: mask part
  logic        any_list_hit;
  logic        any_mask_full_hit;
  logic [7:0]  total_elems;
  logic [7:0]  last_idx;         // last stored index
  logic        last_hit;
  logic        last_list;
  logic        last_full;
  logic [31:0] accept_cnt;
  logic [31:0] drop_cnt;
  logic        next_fifo_wr;
  logic [7:0]  next_last_idx;
  logic        next_last_hit;
  logic        next_last_list;
  logic        next_last_full;
  logic [31:0] next_accept_cnt;
  logic [31:0] next_drop_cnt;

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************

  // next values of the bus channels and the register file
  always_comb begin
    logic        do_wr;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [7:0]  ra;
    do_wr           = 1'b0;
    wmask           = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    merged          = 32'h0000_0000;
    ra              = {i_araddr[7:2], 2'h0};
    next_bank_word  = bank_word;
    next_cfg_reg    = cfg_reg;
    next_mode_reg   = mode_reg;
    next_aw_full    = aw_full;
    next_aw_addr    = aw_addr;
    next_w_full     = w_full;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_bvalid     = o_bvalid;
    next_bresp      = o_bresp;
    next_rvalid     = o_rvalid;
    next_rdata      = o_rdata;
    next_rresp      = o_rresp;
    // address and data may arrive in either order
    if (o_awready && i_awvalid) begin
      next_aw_full = 1'b1;
      next_aw_addr = {i_awaddr[7:2], 2'h0};
    end
    if (o_wready && i_wvalid) begin
      next_w_full = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (o_bvalid && i_bready) next_bvalid = 1'b0;
    // commit once both halves are held and the response slot is free
    if (aw_full && w_full && !o_bvalid) begin
      do_wr        = 1'b1;
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = acc_filter_pkg::RESP_OKAY;
    end
    if (do_wr) begin
      if (addr_is_bank(aw_addr)) begin
        merged = (bank_word[aw_addr[5:2]] & ~wmask) | (w_data & wmask);
        next_bank_word[aw_addr[5:2]] = merged;
      end else if (aw_addr == acc_filter_pkg::ADDR_CONFIG) begin
        next_cfg_reg = ((cfg_reg & ~wmask) | (w_data & wmask)) & 32'h000f_ff3f;
      end else if (aw_addr == acc_filter_pkg::ADDR_MODE) begin
        next_mode_reg = ((mode_reg & ~wmask) | (w_data & wmask)) & 32'h0000_3f3f;
      end else if (aw_addr == acc_filter_pkg::ADDR_MATCH_IDX ||
                   aw_addr == acc_filter_pkg::ADDR_ACCEPT_CNT ||
                   aw_addr == acc_filter_pkg::ADDR_DROP_CNT) begin
        next_bresp = acc_filter_pkg::RESP_OKAY; // read-only, write ignored
      end else begin
        next_bresp = acc_filter_pkg::RESP_SLVERR; // unmapped
      end
    end
    // reads answer one cycle after the address is taken
    if (o_rvalid && i_rready) next_rvalid = 1'b0;
    if (o_arready && i_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = acc_filter_pkg::RESP_OKAY;
      if (addr_is_bank(ra))                             next_rdata = bank_word[ra[5:2]];
      else if (ra == acc_filter_pkg::ADDR_CONFIG)       next_rdata = cfg_reg;
      else if (ra == acc_filter_pkg::ADDR_MODE)         next_rdata = mode_reg;
      else if (ra == acc_filter_pkg::ADDR_MATCH_IDX)
        next_rdata = {22'h000000, last_list, last_hit, last_idx};
      else if (ra == acc_filter_pkg::ADDR_ACCEPT_CNT)   next_rdata = accept_cnt;
      else if (ra == acc_filter_pkg::ADDR_DROP_CNT)     next_rdata = drop_cnt;
      else begin
        next_rdata = 32'h0000_0000;
        next_rresp = acc_filter_pkg::RESP_SLVERR;
      end
    end
    // one outstanding item per channel keeps the slave simple
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    next_arready = !next_rvalid;
  end

  // bus registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < acc_filter_pkg::NUM_WORDS; i++) begin
        bank_word[i] <= acc_filter_pkg::RST_BANK_WORD;
      end
      cfg_reg   <= acc_filter_pkg::RST_CONFIG;  // all banks inactive
      mode_reg  <= acc_filter_pkg::RST_MODE;
      aw_full   <= 1'b0;
      aw_addr   <= 8'h00;
      w_full    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else begin
      bank_word <= next_bank_word;
      cfg_reg   <= next_cfg_reg;
      mode_reg  <= next_mode_reg;
      aw_full   <= next_aw_full;
      aw_addr   <= next_aw_addr;
      w_full    <= next_w_full;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      o_awready <= next_awready;
      o_wready  <= next_wready;
      o_bvalid  <= next_bvalid;
      o_bresp   <= next_bresp;
      o_arready <= next_arready;
      o_rvalid  <= next_rvalid;
      o_rdata   <= next_rdata;
      o_rresp   <= next_rresp;
    end
  end

  // ****************************************************************
  // filter matching
  // ****************************************************************

  // one full scan of all banks; ascending order gives lowest index on ties
  always_comb begin
    logic [63:0] bb;
    logic [9:0]  lay;
    logic [1:0]  kind;
    logic        list;
    logic        full;
    logic [31:0] wm;
    logic [31:0] fa;
    logic [31:0] fb;
    logic        hit_a;
    logic        hit_b;
    logic [1:0]  rank;
    logic [7:0]  cnt;
    bb = 64'h0; lay = 10'h000; kind = 2'h0; list = 1'b0; full = 1'b0;
    wm = 32'h0; fa = 32'h0; fb = 32'h0; hit_a = 1'b0; hit_b = 1'b0; rank = 2'h0;
    cnt               = 8'h00;
    found             = 1'b0;
    best_idx          = 8'h00;
    best_rank         = 2'h3;
    any_list_hit      = 1'b0;
    any_mask_full_hit = 1'b0;
    for (int b = 0; b < acc_filter_pkg::NUM_BANKS; b++) begin
      bb = {bank_word[2*b+1], bank_word[2*b]};
      for (int f = 0; f < acc_filter_pkg::FILTERS_PER_BK; f++) begin
        lay  = filter_layout(cfg_reg[acc_filter_pkg::CFG_SCALE_POS + 2*b +: 2], f);
        kind = lay[8:7];
        list = lay[0] ? high_half_list_mode[b] : low_half_list_mode[b];
        full = (kind != acc_filter_pkg::KIND_8);
        wm   = width_mask(kind);
        fa   = bank_field(bb, lay[6:4], kind);
        fb   = bank_field(bb, lay[3:1], kind);
        if (list) begin // second set is another identifier
          hit_a = ((key_q ^ fa) & wm) == 32'h0;
          hit_b = ((key_q ^ fb) & wm) == 32'h0;
        end else begin  // mask one means must match
          hit_a = ((key_q ^ fa) & fb & wm) == 32'h0;
          hit_b = 1'b0;
        end
        hit_a = hit_a && lay[9] && bank_active[b]; // inactive never hits
        hit_b = hit_b && lay[9] && bank_active[b];
        rank  = {!list, !full};
        if (hit_a || hit_b) begin
          if (list) any_list_hit = 1'b1;
          if (!list && full) any_mask_full_hit = 1'b1;
        end
        // strict compare keeps the earlier, lower index
        if (hit_a && (!found || rank < best_rank)) begin
          found = 1'b1; best_rank = rank; best_idx = cnt;
        end
        if (hit_b && (!found || rank < best_rank)) begin
          found = 1'b1; best_rank = rank; best_idx = cnt + 8'h01;
        end
        // index numbering, one per element of the scale
        if (lay[9]) cnt = cnt + (list ? 8'h02 : 8'h01);
      end
    end
    total_elems = cnt;
  end

  // next store decision and status
  always_comb begin
    next_fifo_wr    = 1'b0;
    next_last_idx   = last_idx;
    next_last_hit   = last_hit;
    next_last_list  = last_list;
    next_last_full  = last_full;
    next_accept_cnt = accept_cnt;
    next_drop_cnt   = drop_cnt;
    if (rx_q) begin
      if (rx_ok_q && found) begin
        next_fifo_wr    = 1'b1;
        next_last_idx   = best_idx;
        next_last_hit   = 1'b1;
        next_last_list  = !best_rank[1];
        next_last_full  = !best_rank[0];
        next_accept_cnt = accept_cnt + 32'h1;
      end else begin // dropped silently, only counted
        next_drop_cnt   = drop_cnt + 32'h1;
      end
    end
  end

  // frame capture and store outputs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_q               <= 1'b0;
      rx_ok_q            <= 1'b0;
      key_q              <= 32'h0000_0000;
      o_fifo_wr          <= 1'b0;
      o_fifo_match_index <= 8'h00;
      last_idx           <= 8'h00;
      last_hit           <= 1'b0;
      last_list          <= 1'b0;
      last_full          <= 1'b0;
      accept_cnt         <= 32'h0000_0000;
      drop_cnt           <= 32'h0000_0000;
    end else begin
      rx_q               <= i_rx_valid;
      rx_ok_q            <= i_rx_frame_ok;
      if (i_rx_valid) key_q <= {i_rx_std_id, i_rx_rtr, i_rx_ide, i_rx_ext_id, 1'b0};
      o_fifo_wr          <= next_fifo_wr;
      o_fifo_match_index <= next_last_idx;
      last_idx           <= next_last_idx;
      last_hit           <= next_last_hit;
      last_list          <= next_last_list;
      last_full          <= next_last_full;
      accept_cnt         <= next_accept_cnt;
      drop_cnt           <= next_drop_cnt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_bad_frame_dropped: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && !rx_ok_q) |=> !o_fifo_wr) else $error("errored frame was stored");
  chk_nomatch_dropped: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && !found) |=> (!o_fifo_wr && drop_cnt == $past(drop_cnt) + 32'h1))
    else $error("unmatched frame not dropped");
  chk_index_carried: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_fifo_wr |-> (o_fifo_match_index == $past(best_idx) && last_idx == o_fifo_match_index))
    else $error("stored index differs from winner");
  chk_inactive_silent: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && bank_active == 6'h00) |=> !o_fifo_wr) else $error("inactive banks matched");
  chk_list_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && rx_ok_q && any_list_hit) |=> (o_fifo_wr && last_list))
    else $error("mask filter beat a list filter");
  chk_full_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && rx_ok_q && !any_list_hit && any_mask_full_hit) |=> (last_full && !last_list))
    else $error("partial filter beat a full one");
  chk_index_range: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && found) |-> (best_idx < total_elems)) else $error("index beyond element count");
  chk_hit_stored: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_q && rx_ok_q && found) |=> o_fifo_wr)
    else $error("matching frame not stored");

endmodule : can_acceptance_filter

//--- verilog/acc_filter_pkg.sv
// ****************************************************************
// acceptance filter constants
// ****************************************************************
package acc_filter_pkg;
  // bank count and filter slots
  localparam int          NUM_BANKS       = 6;
  localparam int          WORDS_PER_BANK  = 2;
  localparam int          NUM_WORDS       = NUM_BANKS * WORDS_PER_BANK;
  localparam int          FILTERS_PER_BK  = 4;
  // byte addresses of the bus-visible registers
  localparam logic [7:0]  ADDR_BANK_LAST  = 8'h2c;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h30;
  localparam logic [7:0]  ADDR_MODE       = 8'h34;
  localparam logic [7:0]  ADDR_MATCH_IDX  = 8'h38;
  localparam logic [7:0]  ADDR_ACCEPT_CNT = 8'h3c;
  localparam logic [7:0]  ADDR_DROP_CNT   = 8'h40;
  // config register fields
  localparam int          CFG_ACTIVE_POS  = 0;
  localparam int          CFG_SCALE_POS   = 8;
  // mode register fields
  localparam int          MODE_LOW_POS    = 0;
  localparam int          MODE_HIGH_POS   = 8;
  // match index register fields
  localparam int          MIDX_HIT_POS    = 8;
  localparam int          MIDX_LIST_POS   = 9;
  // reset values
  localparam logic [31:0] RST_BANK_WORD   = 32'h0000_0000;
  localparam logic [31:0] RST_CONFIG      = 32'h0000_0000;
  localparam logic [31:0] RST_MODE        = 32'h0000_0000;
  // scale encodings
  localparam logic [1:0]  SCALE_32        = 2'h3;
  localparam logic [1:0]  SCALE_16X2      = 2'h2;
  localparam logic [1:0]  SCALE_16_8X2    = 2'h1;
  localparam logic [1:0]  SCALE_8X4       = 2'h0;
  // filter width kinds
  localparam logic [1:0]  KIND_8          = 2'h0;
  localparam logic [1:0]  KIND_16         = 2'h1;
  localparam logic [1:0]  KIND_32         = 2'h2;
  // compared bits in the left-aligned key
  localparam logic [31:0] WMASK_32        = 32'hffff_fffe;
  localparam logic [31:0] WMASK_16        = 32'hfff8_0000;
  localparam logic [31:0] WMASK_8         = 32'hff00_0000;
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : acc_filter_pkg

//--- bench/rx_side_model.sv
`timescale 1ns/1ns
// ****************************************
// receive core and fifo stand-in
// ****************************************
module rx_side_model (
  // clock
  input  wire logic        i_core_clk,
  // fifo store request
  input  wire logic        i_fifo_wr,
  input  wire logic [7:0]  i_fifo_match_index,
  // frame fields to the filter
  output logic             o_rx_valid,
  output logic             o_rx_frame_ok,
  output logic [10:0]      o_rx_std_id,
  output logic             o_rx_ide,
  output logic             o_rx_rtr,
  output logic [17:0]      o_rx_ext_id
);
  int         n_stored   = 0;     // pulses seen, one per stored frame
  logic [7:0] last_index = 8'h00; // index kept with the last frame
  initial begin
    {o_rx_valid, o_rx_frame_ok, o_rx_std_id, o_rx_ide, o_rx_rtr, o_rx_ext_id} = '0;
  end
  // one-cycle frame end; fields inverted after it so stale ids never help
  task automatic send(input logic [10:0] s, input logic r, input logic i, input logic [17:0] e, input logic ok);
    {o_rx_valid, o_rx_frame_ok, o_rx_std_id, o_rx_rtr, o_rx_ide, o_rx_ext_id} <= {1'b1, ok, s, r, i, e};
    @(posedge i_core_clk);
    {o_rx_valid, o_rx_frame_ok, o_rx_std_id, o_rx_rtr, o_rx_ide, o_rx_ext_id} <= {1'b0, ~ok, ~s, ~r, ~i, ~e};
  endtask : send
  // fifo takes every store; overrun lives outside this block
  always @(posedge i_core_clk) begin
    if (i_fifo_wr === 1'b1) begin
      n_stored   <= n_stored + 1;
      last_index <= i_fifo_match_index;
    end
  end
endmodule : rx_side_model

//--- bench/can_acceptance_filter_bench.sv
`timescale 1ns/1ns
// ****************************************
// acceptance filter bench
// ****************************************
module can_acceptance_filter_bench;
  typedef struct packed {logic [10:0] s; logic r; logic i; logic [17:0] e; logic hit; logic [7:0] idx;} row_t;
  logic core_clk = 0, rst_b = 0;
  logic [7:0]  awaddr = 0, araddr = 0, fidx;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, fwr, rxv, rxok, ide, rtr;
  logic [1:0]  bresp, rresp, resp;
  logic [10:0] std;
  logic [17:0] ext;
  int bad_count = 0, n_compared = 0;
  row_t rows [11];
  always #4 core_clk = ~core_clk;
  can_acceptance_filter u_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_rx_valid(rxv),
    .i_rx_frame_ok(rxok), .i_rx_std_id(std), .i_rx_ide(ide), .i_rx_rtr(rtr), .i_rx_ext_id(ext),
    .o_fifo_wr(fwr), .o_fifo_match_index(fidx));
  rx_side_model u_model (.i_core_clk(core_clk), .i_fifo_wr(fwr), .i_fifo_match_index(fidx), .o_rx_valid(rxv),
    .o_rx_frame_ok(rxok), .o_rx_std_id(std), .o_rx_ide(ide), .o_rx_rtr(rtr), .o_rx_ext_id(ext));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    {d, resp} = {rdata, rresp};
  endtask : rd
  // one frame, then count stores after the two-edge answer has landed
  task automatic frame(input row_t w, input logic ok);
    int n0;
    n0 = u_model.n_stored;
    u_model.send(w.s, w.r, w.i, w.e, ok);
    repeat (4) @(posedge core_clk);
    chk("stored", {31'h0, w.hit}, 32'(u_model.n_stored - n0));
    if (w.hit) chk("index", {24'h0, w.idx}, {24'h0, u_model.last_index});
  endtask : frame
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #40000;
    bad_count++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    rows = '{'{11'h123, 0, 1, 18'h2abcd, 1, 0}, '{11'h123, 0, 1, 18'h2abcc, 0, 0}, '{11'h123, 1, 1, 18'h2abcd, 0, 0},
      '{11'h055, 0, 0, 0, 1, 1}, '{11'h066, 0, 0, 18'h3ffff, 1, 2}, '{11'h066, 0, 1, 0, 0, 0},
      '{11'h7f0, 1, 1, 5, 1, 3}, '{11'h703, 0, 0, 0, 1, 5}, '{11'h387, 1, 1, 7, 1, 4},
      '{11'h005, 1, 1, 9, 1, 9}, '{11'h010, 0, 0, 0, 1, 6}};
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h30, d); chk("config reset", 32'h0, d);
    wr(8'h00, 32'h9a57_6d24); wr(8'h04, 32'hffff_ffff);
    wr(8'h08, 32'hc00c_a00a); wr(8'h0c, 32'h00e0_00e0);
    wr(8'h10, 32'h0202_e070); wr(8'h14, 32'hff00_e0e0);
    wr(8'h34, 32'h0000_0006); wr(8'h30, 32'h0000_0b07);
    for (int k = 0; k < 11; k++) frame(rows[k], 1'b1);
    rd(8'h38, d); chk("match status", 32'h0000_0306, d);
    rd(8'h3c, d); chk("accepted", 32'd8, d);
    rd(8'h40, d); chk("dropped", 32'd3, d);
    rd(8'h00, d); chk("bank word", 32'h9a57_6d24, d);
    rd(8'h44, d);
    chk("unmapped read data", 32'h0, d);
    chk("unmapped read resp", 32'h2, {30'h0, resp});
    wr(8'h48, 32'h1); chk("unmapped write", 32'h2, {30'h0, resp});
    frame(rows[3] & ~row_t'(9'h100), 1'b0);
    wr(8'h30, 32'h0000_0b06);
    frame(rows[0] & ~row_t'(9'h100), 1'b1);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h30, d); chk("config after reset", 32'h0, d);
    frame(rows[3] & ~row_t'(9'h100), 1'b1);
    report_and_stop();
  end
endmodule : can_acceptance_filter_bench
